// ### pkg/lpdm_pkg.sv
`default_nettype none
package lpdm_pkg;
	localparam int unsigned WIDTH_DEF = 8;
	localparam int unsigned WIDTH_MIN = 2;
	localparam int unsigned WIDTH_MAX = 32;

	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_SEED   = 8'h04;
	localparam logic [7:0] OFS_POLY   = 8'h08;
	localparam logic [7:0] OFS_DENS_A = 8'h0C;
	localparam logic [7:0] OFS_DENS_B = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_VALUE  = 8'h18;

	localparam int unsigned CTRL_START  = 0;
	localparam int unsigned CTRL_TYPE_A = 1;
	localparam int unsigned CTRL_TYPE_B = 2;
	localparam int unsigned CTRL_CUSTOM = 3;
	localparam int unsigned CTRL_BITS   = 4;

	localparam int unsigned STAT_STARTED = 0;
	localparam int unsigned STAT_WRAP    = 1;
	localparam int unsigned STAT_BITS    = 2;

	localparam logic [31:0] SEED_RST   = 32'h0000_0001;
	localparam logic [31:0] POLY_RST   = 32'h0000_0000;
	localparam logic [31:0] DENS_RST   = 32'h0000_0000;
	localparam logic [3:0]  CTRL_RST   = 4'h0;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Comparison sense of one density output.
	typedef enum logic {
		LPDM_CMP_LE = 1'b0,
		LPDM_CMP_GE = 1'b1
	} lpdm_cmp_t;

	typedef struct packed {
		logic      custom_poly;
		lpdm_cmp_t type_b;
		lpdm_cmp_t type_a;
		logic      start;
	} lpdm_ctrl_t;

	typedef struct packed {
		logic enable;
		logic reload;
		logic kill;
	} lpdm_pins_t;

	// Standard maximal-length Galois taps, right-shifting form.
	function automatic logic [31:0] lpdm_std_poly(input int unsigned width);
		logic [31:0] p;
		case (width)
			2:       p = 32'h0000_0003;
			3:       p = 32'h0000_0006;
			4:       p = 32'h0000_000C;
			5:       p = 32'h0000_0014;
			6:       p = 32'h0000_0030;
			7:       p = 32'h0000_0060;
			8:       p = 32'h0000_00B8;
			9:       p = 32'h0000_0110;
			10:      p = 32'h0000_0240;
			11:      p = 32'h0000_0500;
			12:      p = 32'h0000_0829;
			13:      p = 32'h0000_100D;
			14:      p = 32'h0000_2015;
			15:      p = 32'h0000_6000;
			16:      p = 32'h0000_D008;
			17:      p = 32'h0001_2000;
			18:      p = 32'h0002_0400;
			19:      p = 32'h0004_0023;
			20:      p = 32'h0009_0000;
			21:      p = 32'h0014_0000;
			22:      p = 32'h0030_0000;
			23:      p = 32'h0042_0000;
			24:      p = 32'h00E1_0000;
			25:      p = 32'h0120_0000;
			26:      p = 32'h0200_0023;
			27:      p = 32'h0400_0013;
			28:      p = 32'h0900_0000;
			29:      p = 32'h1400_0000;
			30:      p = 32'h2000_0029;
			31:      p = 32'h4800_0000;
			default: p = 32'h8020_0003;
		endcase
		return p;
	endfunction

	// Merges a write word into a register under its byte strobes.
	function automatic logic [31:0] lpdm_strobe(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = data[8*i +: 8];
			end
		end
		return r;
	endfunction
endpackage
`default_nettype wire

// ### rtl/lpdm_compare.sv
`default_nettype none
module lpdm_compare #(
	parameter int unsigned WIDTH = lpdm_pkg::WIDTH_DEF
) (
	input  wire logic               [WIDTH-1:0] value,
	input  wire logic               [WIDTH-1:0] density,
	input  wire lpdm_pkg::lpdm_cmp_t            mode,
	output logic                                hit
);
	wire logic le_hit;
	wire logic ge_hit;

	assign le_hit = value <= density; // [R10]
	assign ge_hit = value >= density; // [R11]
	assign hit    = (mode == lpdm_pkg::LPDM_CMP_GE) ? ge_hit : le_hit;
endmodule
`default_nettype wire

// ### rtl/lpdm_lfsr.sv
`default_nettype none
module lpdm_lfsr #(
	parameter int unsigned WIDTH = lpdm_pkg::WIDTH_DEF
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             load,
	input  wire logic             step,
	input  wire logic [WIDTH-1:0] seed,
	input  wire logic [WIDTH-1:0] poly,
	output logic      [WIDTH-1:0] value_q,
	output logic      [WIDTH-1:0] value_d
);
	wire logic [WIDTH-1:0] shifted;
	wire logic [WIDTH-1:0] feedback;

	// Galois form: the bit shifted out folds back into every tap at once, so one XOR level per bit. [R02]
	assign shifted  = value_q >> 1;
	assign feedback = value_q[0] ? poly : '0;

	always_comb begin
		value_d = value_q;
		if (load) begin
			value_d = seed; // [R06]
		end else if (step) begin
			value_d = shifted ^ feedback; // [R05]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			value_q <= lpdm_pkg::SEED_RST[WIDTH-1:0];
		end else begin
			value_q <= value_d; // [R16]
		end
	end
endmodule
`default_nettype wire

// ### rtl/lpdm_top.sv
// How it works
// R01 - The sequence width is a build-time parameter from 2 to 32 bits and sets the comparison resolution.
// R02 - The sequence comes from a Galois shift register with a maximal-length feedback polynomial.
// R03 - For every width the polynomial is either the built-in standard one or a custom value from software.
// R04 - The start value is software-set and any nonzero value is allowed, since zero would lock the register.
// R05 - The register steps once per clock only while enable is high and reload is low, else it holds.
// R06 - While reload is high the register is loaded with the configured start value.
// R07 - Reload has no effect on the register until the block has been started.
// R08 - While kill is high both density outputs are forced low, and they resume when kill falls.
// R09 - Two density outputs compare the same shared sequence value against their own density values.
// R10 - In less-or-equal mode an output is high exactly while the value does not exceed its density.
// R11 - In greater-or-equal mode an output is high exactly while the value is at least its density.
// R12 - Density values reach from never high to always high over one sequence period; in greater-or-equal mode the lowest is one high clock per period.
// R13 - The serial output always carries the least significant bit of the register.
// R14 - The wrap pulse exists only for widths of 8, 16, 24 and 32 bits.
// R15 - The wrap pulse is high for one clock each time the value becomes all ones, once per period.
// R16 - Every state change happens on the rising clock edge and every output comes from a flip-flop.
`default_nettype none
module lpdm_top #(
	parameter int unsigned WIDTH = lpdm_pkg::WIDTH_DEF
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        enable,
	input  wire logic        reload,
	input  wire logic        kill,
	output logic             density_out_a,
	output logic             density_out_b,
	output logic             bitstream,
	output logic             sequence_wrap_pulse
);
	localparam logic [WIDTH-1:0] ALL_ONES = '1;
	localparam bit HAS_WRAP = (WIDTH == 8) || (WIDTH == 16) || (WIDTH == 24) || (WIDTH == 32); // [R14]
	localparam logic [31:0] STD_POLY = lpdm_pkg::lpdm_std_poly(WIDTH); // [R03]

	typedef enum logic [1:0] {
		WR_IDLE = 2'b01,
		WR_RESP = 2'b10
	} lpdm_wr_state_t;

	// Control pins come from other components on unknown timing, so each passes two flip-flops.
	lpdm_pkg::lpdm_pins_t pins_meta_q;
	lpdm_pkg::lpdm_pins_t pins_q;

	lpdm_pkg::lpdm_ctrl_t ctrl_q;
	logic [WIDTH-1:0]     seed_q;
	logic [WIDTH-1:0]     poly_q;
	logic [WIDTH-1:0]     dens_a_q;
	logic [WIDTH-1:0]     dens_b_q;

	lpdm_wr_state_t       wr_state_q;
	logic                 aw_have_q;
	logic                 w_have_q;
	logic [7:0]           aw_addr_q;
	logic [31:0]          w_data_q;
	logic [3:0]           w_strb_q;

	logic [WIDTH-1:0]     value_q;
	logic [WIDTH-1:0]     value_d;
	logic                 hit_a;
	logic                 hit_b;

	wire logic            started;
	wire logic            do_load;
	wire logic            do_step;
	wire logic [WIDTH-1:0] poly_sel;
	wire logic            do_write;
	wire logic            wr_ctrl;
	wire logic            wr_seed;
	wire logic            wr_poly;
	wire logic            wr_dens_a;
	wire logic            wr_dens_b;
	wire logic            wr_mapped;
	wire logic [31:0]     wr_word;
	wire logic [WIDTH-1:0] seed_new;
	wire logic            rd_take;
	wire logic [31:0]     wr_old;
	wire logic            rd_mapped;
	wire logic [31:0]     rd_word;
	wire logic [31:0]     status_word;
	wire logic            wrap_next;

	assign started = ctrl_q.start;
	// Reload only counts once started; stepping needs start too, because the block only runs after it starts.
	assign do_load  = started && pins_q.reload; // [R07]
	assign do_step  = started && pins_q.enable && !pins_q.reload; // [R05]
	assign poly_sel = ctrl_q.custom_poly ? poly_q : STD_POLY[WIDTH-1:0]; // [R03]

	lpdm_lfsr #(
		.WIDTH(WIDTH)
	) u_lfsr (
		.aclk   (aclk),
		.aresetn(aresetn),
		.load   (do_load),
		.step   (do_step),
		.seed   (seed_q),
		.poly   (poly_sel),
		.value_q(value_q),
		.value_d(value_d)
	);

	// Both comparators watch the one shared value so the two outputs stay correlated. [R09]
	lpdm_compare #(
		.WIDTH(WIDTH)
	) u_cmp_a (
		.value  (value_q),
		.density(dens_a_q),
		.mode   (ctrl_q.type_a),
		.hit    (hit_a)
	);

	lpdm_compare #(
		.WIDTH(WIDTH)
	) u_cmp_b (
		.value  (value_q),
		.density(dens_b_q),
		.mode   (ctrl_q.type_b),
		.hit    (hit_b)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pins_meta_q <= '0;
			pins_q      <= '0;
		end else begin
			pins_meta_q <= {enable, reload, kill};
			pins_q      <= pins_meta_q;
		end
	end

	// Outputs are registered from the value, so they trail the register by one clock. [R16]
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			density_out_a <= 1'b0;
			density_out_b <= 1'b0;
			bitstream     <= 1'b0;
		end else begin
			density_out_a <= hit_a && !pins_q.kill; // [R08]
			density_out_b <= hit_b && !pins_q.kill; // [R08]
			bitstream     <= value_q[0]; // [R13]
		end
	end

	// The pulse marks the step into all ones, so a stalled register does not stretch it. [R15]
	assign wrap_next = HAS_WRAP && do_step && !do_load && (value_d == ALL_ONES);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sequence_wrap_pulse <= 1'b0;
		end else begin
			sequence_wrap_pulse <= wrap_next; // [R14] [R15]
		end
	end

	// Write channel: address and data are caught in either order, then applied together.
	assign do_write  = (wr_state_q == WR_IDLE) && aw_have_q && w_have_q;
	assign wr_ctrl   = aw_addr_q == lpdm_pkg::OFS_CTRL;
	assign wr_seed   = aw_addr_q == lpdm_pkg::OFS_SEED;
	assign wr_poly   = aw_addr_q == lpdm_pkg::OFS_POLY;
	assign wr_dens_a = aw_addr_q == lpdm_pkg::OFS_DENS_A;
	assign wr_dens_b = aw_addr_q == lpdm_pkg::OFS_DENS_B;
	assign wr_mapped = wr_ctrl || wr_seed || wr_poly || wr_dens_a || wr_dens_b;
	assign wr_word   = lpdm_pkg::lpdm_strobe(wr_old, w_data_q, w_strb_q);
	assign seed_new  = wr_word[WIDTH-1:0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr[7:0];
		end else if (do_write) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end else if (do_write) begin
			w_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) && (wr_state_q == WR_IDLE);
			s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready) && (wr_state_q == WR_IDLE);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_q   <= WR_IDLE;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= lpdm_pkg::RESP_OKAY;
		end else begin
			case (wr_state_q)
				WR_IDLE: begin
					if (do_write) begin
						wr_state_q   <= WR_RESP;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp  <= wr_mapped ? lpdm_pkg::RESP_OKAY : lpdm_pkg::RESP_SLVERR;
					end
				end
				WR_RESP: begin
					if (s_axi_bready) begin
						wr_state_q   <= WR_IDLE;
						s_axi_bvalid <= 1'b0;
					end
				end
				default: begin
					wr_state_q   <= WR_IDLE;
					s_axi_bvalid <= 1'b0;
				end
			endcase
		end
	end

	// The width limit is fixed at build; widths outside 2..32 are not supported. [R01]
	// Density registers span the full width, so in less-or-equal mode zero and all ones give never and always high. [R12]
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q   <= lpdm_pkg::CTRL_RST;
			seed_q   <= lpdm_pkg::SEED_RST[WIDTH-1:0];
			poly_q   <= lpdm_pkg::POLY_RST[WIDTH-1:0];
			dens_a_q <= lpdm_pkg::DENS_RST[WIDTH-1:0];
			dens_b_q <= lpdm_pkg::DENS_RST[WIDTH-1:0];
		end else if (do_write) begin
			if (wr_ctrl) begin
				ctrl_q <= wr_word[lpdm_pkg::CTRL_BITS-1:0];
			end
			// A zero seed is dropped and the old one kept, since zero would lock the register. [R04]
			if (wr_seed && (seed_new != '0)) begin
				seed_q <= seed_new;
			end
			if (wr_poly) begin
				poly_q <= wr_word[WIDTH-1:0]; // [R03]
			end
			if (wr_dens_a) begin
				dens_a_q <= wr_word[WIDTH-1:0];
			end
			if (wr_dens_b) begin
				dens_b_q <= wr_word[WIDTH-1:0];
			end
		end
	end

	// Read channel: one read at a time; the strobe merge runs the same decode on its own address.
	// A write therefore never stalls a read, at the cost of a second copy of the read-back mux.
	function automatic logic [31:0] reg_word(input logic [7:0] addr, input logic [31:0] c, input logic [31:0] s,
			input logic [31:0] p, input logic [31:0] da, input logic [31:0] db, input logic [31:0] st,
			input logic [31:0] v);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (addr == lpdm_pkg::OFS_CTRL) begin
			r = c;
		end else if (addr == lpdm_pkg::OFS_SEED) begin
			r = s;
		end else if (addr == lpdm_pkg::OFS_POLY) begin
			r = p;
		end else if (addr == lpdm_pkg::OFS_DENS_A) begin
			r = da;
		end else if (addr == lpdm_pkg::OFS_DENS_B) begin
			r = db;
		end else if (addr == lpdm_pkg::OFS_STATUS) begin
			r = st;
		end else if (addr == lpdm_pkg::OFS_VALUE) begin
			r = v;
		end
		return r;
	endfunction

	assign rd_take     = s_axi_arvalid && s_axi_arready;
	assign status_word = {{(32 - lpdm_pkg::STAT_BITS){1'b0}}, sequence_wrap_pulse, started};
	assign rd_mapped   = (s_axi_araddr[7:0] == lpdm_pkg::OFS_CTRL) || (s_axi_araddr[7:0] == lpdm_pkg::OFS_SEED)
		|| (s_axi_araddr[7:0] == lpdm_pkg::OFS_POLY) || (s_axi_araddr[7:0] == lpdm_pkg::OFS_DENS_A)
		|| (s_axi_araddr[7:0] == lpdm_pkg::OFS_DENS_B) || (s_axi_araddr[7:0] == lpdm_pkg::OFS_STATUS)
		|| (s_axi_araddr[7:0] == lpdm_pkg::OFS_VALUE);
	assign rd_word     = reg_word(s_axi_araddr[7:0], 32'(ctrl_q), 32'(seed_q), 32'(poly_q), 32'(dens_a_q),
		32'(dens_b_q), status_word, 32'(value_q));
	assign wr_old      = reg_word(aw_addr_q, 32'(ctrl_q), 32'(seed_q), 32'(poly_q), 32'(dens_a_q),
		32'(dens_b_q), status_word, 32'(value_q));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= lpdm_pkg::RESP_OKAY;
		end else if (rd_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_mapped ? lpdm_pkg::RESP_OKAY : lpdm_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid) begin
			s_axi_arready <= 1'b0;
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### testbench/lpdm_load_model.sv
`default_nettype none
// Light stage load: counts on-cycles of each density output and wrap pulses in a window.
module lpdm_load_model (
	input wire logic         aclk,
	input wire logic         clr,
	input wire logic         win,
	input wire logic         density_out_a,
	input wire logic         density_out_b,
	input wire logic         sequence_wrap_pulse,
	output logic      [15:0] cnt_a,
	output logic      [15:0] cnt_b,
	output logic      [15:0] cnt_w
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge aclk) begin
		if (clr) begin
			cnt_a <= 16'h0;
			cnt_b <= 16'h0;
			cnt_w <= 16'h0;
		end else if (win) begin
			cnt_a <= cnt_a + 16'(density_out_a);
			cnt_b <= cnt_b + 16'(density_out_b);
			cnt_w <= cnt_w + 16'(sequence_wrap_pulse);
		end
	end
endmodule
`default_nettype wire

// ### testbench/lpdm_top_asserts.sv
`default_nettype none
module lpdm_top_asserts #(
	parameter int unsigned WIDTH = lpdm_pkg::WIDTH_DEF
) (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        enable,
	input wire logic        reload,
	input wire logic        kill,
	input wire logic        density_out_a,
	input wire logic        density_out_b,
	input wire logic        bitstream,
	input wire logic        sequence_wrap_pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	kill_low_a: assert property (kill [*3] |=> !density_out_a && !density_out_b)
		else $error("density output high under kill");
	wrap_single_a: assert property (sequence_wrap_pulse |=> !sequence_wrap_pulse)
		else $error("wrap pulse longer than one clock");
	wrap_gap_a: assert property (sequence_wrap_pulse ##1 !sequence_wrap_pulse |=> !sequence_wrap_pulse [*8])
		else $error("wrap pulse repeats too soon");
	// Pin inputs pass a two-flop synchroniser, so five idle samples are needed before the state is frozen.
	bit_hold_a: assert property (!enable && !reload [*5] |=> $stable(bitstream))
		else $error("bitstream moved while stopped");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read response dropped early");
	read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");

	cover property (sequence_wrap_pulse);
	cover property (kill [*3] ##1 !kill);
	cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind lpdm_top lpdm_top_asserts #(.WIDTH(WIDTH)) u_chk (
	.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.enable, .reload, .kill, .density_out_a, .density_out_b, .bitstream, .sequence_wrap_pulse
);
`default_nettype wire

// ### testbench/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 1'h0, aresetn = 1'h0, clr = 1'h0, win = 1'h0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
	logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, enable = 1'h0, reload = 1'h0, kill = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        density_out_a, density_out_b, bitstream, sequence_wrap_pulse;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [15:0] cnt_a, cnt_b, cnt_w;
	int          n_mismatch = 0, checks = 0;

	always #10 aclk = ~aclk;

	lpdm_top #(.WIDTH(8)) dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .enable, .reload, .kill, .density_out_a, .density_out_b,
		.bitstream, .sequence_wrap_pulse
	);
	lpdm_load_model u_load (.aclk, .clr, .win, .density_out_a, .density_out_b, .sequence_wrap_pulse,
		.cnt_a, .cnt_b, .cnt_w);

	task automatic test_done();
		if (n_mismatch == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic hang();
		n_mismatch++;
		test_done();
	endtask

	// Ready for the answer from the start; one idle edge after each transfer keeps strobes from toggling in a step.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (++n > 200) hang();
			if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		chk("bresp", 32'(er), 32'(s_axi_bresp));
		@(posedge aclk);
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (++n > 200) hang();
			if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		chk("rdata", ed, s_axi_rdata);
		chk("rresp", 32'(er), 32'(s_axi_rresp));
		@(posedge aclk);
	endtask

	task automatic pins(input logic en, input logic rl, input logic kl, input int n);
		enable <= en;
		reload <= rl;
		kill <= kl;
		repeat (n) @(posedge aclk);
	endtask

	function automatic logic [7:0] steps(input logic [7:0] v, input logic [7:0] p, input int n);
		repeat (n) v = (v >> 1) ^ (v[0] ? p : 8'h00);
		return v;
	endfunction

	task automatic t_regs();
		logic [7:0]  a [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
		logic [31:0] e [7] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1};
		chk("outputs", 32'h0, {29'h0, density_out_a, density_out_b, sequence_wrap_pulse});
		for (int i = 0; i < 7; i++) axi_rd(a[i], e[i], 2'h0);
		axi_rd(8'h1C, 32'h0, 2'h2);
		axi_wr(8'h14, 32'hFFFF_FFFF, 2'h2);
		axi_rd(8'h14, 32'h0, 2'h0);
		// Byte lane 0 is masked, so the density value must keep its reset value.
		s_axi_wstrb <= 4'hE;
		axi_wr(8'h0C, 32'hFF, 2'h0);
		s_axi_wstrb <= 4'hF;
		axi_rd(8'h0C, 32'h0, 2'h0);
	endtask

	task automatic t_prestart();
		axi_wr(8'h04, 32'h5A, 2'h0);
		axi_wr(8'h04, 32'h0, 2'h0);
		pins(1'h0, 1'h1, 1'h0, 6);
		pins(1'h1, 1'h0, 1'h0, 6);
		pins(1'h0, 1'h0, 1'h0, 4);
		axi_rd(8'h18, 32'h1, 2'h0);
		axi_rd(8'h04, 32'h5A, 2'h0);
	endtask

	task automatic t_step();
		logic [7:0] ev;
		axi_wr(8'h00, 32'h1, 2'h0);
		axi_rd(8'h14, 32'h1, 2'h0);
		pins(1'h0, 1'h1, 1'h0, 6);
		pins(1'h0, 1'h0, 1'h0, 4);
		axi_rd(8'h18, 32'h5A, 2'h0);
		pins(1'h1, 1'h0, 1'h0, 20);
		pins(1'h0, 1'h0, 1'h0, 4);
		ev = steps(8'h5A, 8'hB8, 20);
		axi_rd(8'h18, 32'(ev), 2'h0);
		chk("bitstream", 32'(ev[0]), 32'(bitstream));
		axi_wr(8'h08, 32'h8E, 2'h0);
		axi_wr(8'h00, 32'h9, 2'h0);
		pins(1'h0, 1'h1, 1'h0, 6);
		pins(1'h1, 1'h0, 1'h0, 37);
		pins(1'h0, 1'h0, 1'h0, 4);
		axi_rd(8'h18, 32'(steps(8'h5A, 8'h8E, 37)), 2'h0);
		pins(1'h1, 1'h1, 1'h0, 8);
		pins(1'h0, 1'h0, 1'h0, 4);
		axi_rd(8'h18, 32'h5A, 2'h0);
	endtask

	task automatic t_dens();
		logic [7:0]  cc [4] = '{8'h5, 8'h3, 8'h5, 8'h5};
		logic [7:0]  da [4] = '{8'h7F, 8'h00, 8'hFF, 8'hFF};
		logic [7:0]  db [4] = '{8'h80, 8'h00, 8'hFF, 8'hFF};
		logic        kk [4] = '{1'h0, 1'h0, 1'h1, 1'h0};
		logic [15:0] ea [4] = '{16'h007F, 16'h00FF, 16'h0000, 16'h00FF};
		logic [15:0] eb [4] = '{16'h0080, 16'h0000, 16'h0000, 16'h0001};
		// Kill is checked in the third case and its release in the fourth.
		for (int i = 0; i < 4; i++) begin
			axi_wr(8'h00, 32'(cc[i]), 2'h0);
			axi_wr(8'h0C, 32'(da[i]), 2'h0);
			axi_wr(8'h10, 32'(db[i]), 2'h0);
			pins(1'h1, 1'h0, kk[i], 6);
			clr <= 1'h1;
			@(posedge aclk);
			clr <= 1'h0;
			win <= 1'h1;
			repeat (255) @(posedge aclk);
			win <= 1'h0;
			@(posedge aclk);
			chk("density_out_a count", 32'(ea[i]), 32'(cnt_a));
			chk("density_out_b count", 32'(eb[i]), 32'(cnt_b));
			chk("wrap count", 32'h1, 32'(cnt_w));
		end
	endtask

	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		t_regs();
		t_prestart();
		t_step();
		t_dens();
		test_done();
	end
endmodule
`default_nettype wire
